/* File: core/interval_timer.sv */
// Reloadable down-counting interval timer used for period, delay and width.
// Assumes one clock, a synchronous start strobe and a clock enable from the parent.
`timescale 1ns/100ps
module interval_timer #(
  parameter int TW = 32
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic start, // Reload and start the interval
  input wire logic [TW-1:0] load_val, // Interval length in cycles
  output logic active, // High while the interval runs
  output logic last // High in the final cycle of the interval
);

  typedef struct packed {
    logic act;
    logic [TW-1:0] cnt;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  // Next state: a start reloads even while running; zero acts as one cycle
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.act = 1'b1;
      next_s.cnt = (load_val == '0) ? TW'(1) : load_val;
    end else if (s.act) begin
      if (s.cnt == TW'(1)) begin
        next_s.act = 1'b0;
      end else begin
        next_s.cnt = s.cnt - TW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign active = s.act;
  assign last = s.act && (s.cnt == TW'(1));

endmodule // interval_timer

/* File: core/pms_pkg.sv */
// Constants shared by the pulse mode sequencer and its testbench.
// Assumes every user writes pms_pkg::name; nothing is imported.
package pms_pkg;

  // ****************************************
  // Register map (byte offsets, AXI4-Lite)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] WIDTH_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_REMOTE_BIT = 3;
  localparam int CTRL_EXT_BIT = 4;
  localparam int CTRL_NEG_BIT = 5;
  localparam int CTRL_FIRE_BIT = 6;
  localparam logic [7:0] CTRL_STORE_MASK = 8'h3f;

  // ****************************************
  // Reset values (intervals in core_clk cycles)
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] PERIOD_RST = 32'h00000064;
  localparam logic [31:0] DELAY_RST = 32'h00000014;
  localparam logic [31:0] WIDTH_RST = 32'h0000000a;

  // ****************************************
  // Mode codes and modes
  // ****************************************
  localparam logic [2:0] CODE_SINGLE = 3'h0;
  localparam logic [2:0] CODE_DELAYED = 3'h1;
  localparam logic [2:0] CODE_DOUBLE = 3'h2;
  localparam logic [2:0] CODE_BURST = 3'h3;
  localparam logic [2:0] CODE_GATED = 3'h4;

  typedef enum logic [4:0] {
    MODE_SINGLE = 5'h01,
    MODE_DELAYED = 5'h02,
    MODE_DOUBLE = 5'h04,
    MODE_BURST = 5'h08,
    MODE_GATED = 5'h10
  } pulse_mode_t;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: core/pulse_mode_sequencer.sv */
// Pulse mode sequencer: period, delay and width timers steered by five pulse modes.
// Assumes an AXI4-Lite master on core_clk and trigger, gate and remote inputs synchronous to it.
//
// Functional notes
// R1 - Internal single mode: period timer free-runs
// R2 - Each period cycle triggers width, delay, pretrigger
// R3 - Single mode: one pulse per period cycle
// R4 - Delay starts on trigger, runs programmed interval
// R5 - Delay expiry emits late trigger pulse
// R6 - Width timer starts with delay timer
// R7 - Width gate sets output pulse width
// R8 - Negative polarity inverts the output pulse
// R9 - Delayed mode: delay expiry starts width timer
// R10 - Delayed mode: late trigger precedes delayed pulse
// R11 - Double mode: both triggers start width timer
// R12 - Double mode: late trigger precedes second pulse
// R13 - Burst mode: period runs only inside delay gate
// R14 - Burst mode: external trigger starts each burst
// R15 - Burst mode: period triggers reach width in gate
// R16 - Burst mode: late trigger at burst end
// R17 - Gated mode: external gate enables period timer
// R18 - Gated mode: late trigger follows each period trigger
// R19 - Remote select takes mode from remote inputs
// R20 - External source disables period, external triggers drive; the code ignores the external source bit in burst and gated modes
// R21 - Intervals counted in clock cycles, reload on start
`timescale 1ns/100ps
module pulse_mode_sequencer #(
  parameter int TW = 32, // Timer width, at most 32
  parameter int AW = 8 // Register address width
) (
  input wire logic core_clk, // System clock, 25 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic ext_trig, // External trigger, rising edge counts
  input wire logic ext_gate, // External gate, high enables period timer
  input wire logic [2:0] remote_mode, // Mode code from remote connector
  output logic pulse_out, // Shaped output pulse
  output logic pretrig_out, // Advance trigger, one cycle per period
  output logic late_trig_out, // Late trigger, one cycle at delay end
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic awready;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic wready;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [TW-1:0] period;
    logic [TW-1:0] delay;
    logic [TW-1:0] width;
    logic fire;
    logic trig_prev;
    logic pulse;
    logic pretrig;
    logic late;
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;

  pms_pkg::pulse_mode_t mode;
  logic [2:0] mode_code;
  logic ext_src;
  logic ext_fire;
  logic period_run;
  logic period_tick;
  logic trig;
  logic delay_start;
  logic width_start;
  logic p_active;
  logic p_last;
  logic d_active;
  logic d_last;
  logic w_active;
  logic delay_too_long;

  // ****************************************
  // Mode selection
  // ****************************************

  // Remote code replaces the panel code when remote select is set
  assign mode_code = s.ctrl[pms_pkg::CTRL_REMOTE_BIT] ? remote_mode : s.ctrl[pms_pkg::CTRL_MODE_LSB +: 3]; // [R19]

  // Decode mode code; unused codes fall back to single
  always_comb begin
    case (mode_code)
      pms_pkg::CODE_SINGLE: mode = pms_pkg::MODE_SINGLE;
      pms_pkg::CODE_DELAYED: mode = pms_pkg::MODE_DELAYED;
      pms_pkg::CODE_DOUBLE: mode = pms_pkg::MODE_DOUBLE;
      pms_pkg::CODE_BURST: mode = pms_pkg::MODE_BURST;
      pms_pkg::CODE_GATED: mode = pms_pkg::MODE_GATED;
      default: mode = pms_pkg::MODE_SINGLE;
    endcase
  end

  // ****************************************
  // Trigger routing
  // ****************************************

  // External trigger edge or a software manual fire
  assign ext_src = s.ctrl[pms_pkg::CTRL_EXT_BIT];
  assign ext_fire = (ext_trig && !s.trig_prev) || s.fire;

  // Which gate lets the period timer run
  always_comb begin
    case (mode)
      pms_pkg::MODE_BURST: period_run = d_active; // [R13]
      pms_pkg::MODE_GATED: period_run = ext_gate; // [R17]
      default: period_run = !ext_src; // [R1] [R20]
    endcase
  end

  // Period trigger at start and at each expiry of the period timer
  assign period_tick = period_run && (!p_active || p_last); // [R1] [R2]

  // Trigger that starts delay and width timers together in single, double and gated modes
  always_comb begin
    case (mode)
      pms_pkg::MODE_BURST: trig = period_tick;
      pms_pkg::MODE_GATED: trig = period_tick;
      default: trig = ext_src ? ext_fire : period_tick; // [R20]
    endcase
  end

  // Delay timer start: external trigger opens the burst gate in burst mode
  assign delay_start = (mode == pms_pkg::MODE_BURST) ? ext_fire : trig; // [R4] [R14] [R18]

  // Width timer start per mode
  always_comb begin
    case (mode)
      pms_pkg::MODE_SINGLE: width_start = trig; // [R3] [R6]
      pms_pkg::MODE_DELAYED: width_start = d_last; // [R9]
      pms_pkg::MODE_DOUBLE: width_start = trig || d_last; // [R11]
      pms_pkg::MODE_BURST: width_start = period_tick && d_active; // [R15]
      pms_pkg::MODE_GATED: width_start = trig;
      default: width_start = trig;
    endcase
  end

  // Delay that does not fit inside the period is flagged in status
  assign delay_too_long = (s.delay >= s.period); // [R4]

  // ****************************************
  // Interval timers
  // ****************************************

  // Period timer, reloaded on every period trigger
  interval_timer #(.TW(TW)) u_period_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(period_tick), // [R21]
    .load_val(s.period),
    .active(p_active),
    .last(p_last)
  );

  // Delay timer, doubles as burst gate
  interval_timer #(.TW(TW)) u_delay_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(delay_start), // [R21]
    .load_val(s.delay),
    .active(d_active),
    .last(d_last)
  );

  // Width timer, its activity is the width gate
  interval_timer #(.TW(TW)) u_width_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(width_start), // [R21]
    .load_val(s.width),
    .active(w_active),
    .last()
  );

  // ****************************************
  // Register write merge
  // ****************************************

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Next state
  // ****************************************

  // Bus slave, registers and output stage
  always_comb begin
    logic [31:0] merged;
    merged = '0;
    next_s = s;
    next_s.fire = 1'b0;
    next_s.trig_prev = ext_trig;
    // Output stage
    next_s.pulse = w_active ^ s.ctrl[pms_pkg::CTRL_NEG_BIT]; // [R7] [R8]
    next_s.pretrig = period_tick; // [R2]
    next_s.late = d_last; // [R5] [R10] [R12] [R16] [R18]
    // Write channels taken independently
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Perform the write once both halves are held and no response is pending
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = pms_pkg::RESP_OKAY;
      case (s.aw_addr[7:0])
        pms_pkg::CTRL_OFS: begin
          merged = merge_bytes({24'h000000, s.ctrl}, s.w_data, s.w_strb);
          next_s.ctrl = merged[7:0] & pms_pkg::CTRL_STORE_MASK;
          next_s.fire = s.w_strb[0] && merged[pms_pkg::CTRL_FIRE_BIT];
        end
        pms_pkg::PERIOD_OFS: begin
          merged = merge_bytes(32'(s.period), s.w_data, s.w_strb);
          next_s.period = merged[TW-1:0];
        end
        pms_pkg::DELAY_OFS: begin
          merged = merge_bytes(32'(s.delay), s.w_data, s.w_strb);
          next_s.delay = merged[TW-1:0];
        end
        pms_pkg::WIDTH_OFS: begin
          merged = merge_bytes(32'(s.width), s.w_data, s.w_strb);
          next_s.width = merged[TW-1:0];
        end
        default: begin
          next_s.bresp = pms_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_got;
    next_s.wready = !next_s.w_got;
    // Read channel, answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = pms_pkg::RESP_OKAY;
      case (s_axi_araddr[7:0])
        pms_pkg::CTRL_OFS: next_s.rdata = {24'h000000, s.ctrl};
        pms_pkg::PERIOD_OFS: next_s.rdata = 32'(s.period);
        pms_pkg::DELAY_OFS: next_s.rdata = 32'(s.delay);
        pms_pkg::WIDTH_OFS: next_s.rdata = 32'(s.width);
        pms_pkg::STATUS_OFS: next_s.rdata = {23'h0, delay_too_long, period_run, w_active, d_active, mode};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = pms_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  // ****************************************
  // State register
  // ****************************************

  // Reset values, then update on clock enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.ctrl <= pms_pkg::CTRL_RST;
      s.period <= pms_pkg::PERIOD_RST[TW-1:0];
      s.delay <= pms_pkg::DELAY_RST[TW-1:0];
      s.width <= pms_pkg::WIDTH_RST[TW-1:0];
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pulse_out = s.pulse;
  assign pretrig_out = s.pretrig;
  assign late_trig_out = s.late;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

endmodule // pulse_mode_sequencer

/* File: dv/pms_checker_asserts.sv */
// Checker on the bus handshakes and trigger outputs of the sequencer.
// Assumes it is bound to pulse_mode_sequencer and that ce drops only while bus and triggers are idle.
`timescale 1ns/100ps
module pms_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pretrig_out,
  input wire logic late_trig_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_pretrig_one: assert property (pretrig_out |=> !pretrig_out)
    else $error("advance trigger longer than one cycle");
  a_late_one: assert property (late_trig_out |=> !late_trig_out)
    else $error("late trigger longer than one cycle");
  a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !pretrig_out)
    else $error("outputs busy after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while answering");
endmodule // pms_checker

bind pulse_mode_sequencer pms_checker chk (.core_clk(core_clk), .rst_n(rst_n), .pretrig_out(pretrig_out),
  .late_trig_out(late_trig_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

/* File: dv/pms_src_model.sv */
// Model of the external trigger, gate and remote program sources.
// Assumes the bench calls its tasks; every line changes just after core_clk rises.
`timescale 1ns/100ps
module pms_src_model (
  input wire logic core_clk, // System clock
  output logic ext_trig, // Trigger line
  output logic ext_gate, // Gate line
  output logic [2:0] remote_mode // Remote mode code
);
  // Idle levels from time zero
  initial begin
    ext_trig = 1'b0;
    ext_gate = 1'b0;
    remote_mode = 3'h0;
  end
  // One trigger, two cycles high, so exactly one rising edge
  task automatic kick();
    @(posedge core_clk);
    ext_trig <= 1'b1;
    repeat (2) @(posedge core_clk);
    ext_trig <= 1'b0;
  endtask
  // Gate level and remote mode code
  task automatic set(input logic g, input logic [2:0] m);
    @(posedge core_clk);
    ext_gate <= g;
    remote_mode <= m;
  endtask
endmodule // pms_src_model

/* File: dv/tb_pulse_mode_sequencer.sv */
// Bench for the pulse mode sequencer: registers, the five modes, polarity, remote and external triggers.
// Assumes the package, design, source model and checker are compiled first.
`timescale 1ns/100ps
module tb_pulse_mode_sequencer;
  localparam int K = 4;
  localparam int W = 3;
  localparam logic [1:0] OK = pms_pkg::RESP_OKAY;
  logic core_clk, rst_n, ce, pulse_out, pretrig_out, late_trig_out, ext_trig, ext_gate;
  logic [2:0] remote_mode;
  logic [7:0] awaddr, araddr, npre, nlate;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, snap;
  logic [15:0] nhigh;
  logic [33:0] expq[$];
  logic [2:0] codes [4] = '{pms_pkg::CODE_SINGLE, pms_pkg::CODE_DELAYED, pms_pkg::CODE_DOUBLE, pms_pkg::CODE_GATED};
  int fails, tests_run, p, hi;

  pulse_mode_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .ext_trig(ext_trig),
    .ext_gate(ext_gate), .remote_mode(remote_mode), .pulse_out(pulse_out), .pretrig_out(pretrig_out),
    .late_trig_out(late_trig_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pms_src_model src (.core_clk(core_clk), .ext_trig(ext_trig), .ext_gate(ext_gate), .remote_mode(remote_mode));

  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Compare a result with the oldest note
  task automatic cmp(input logic [33:0] got);
    tests_run++;
    if (expq.size() == 0 || got !== expq[0]) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expq.size() != 0 ? expq[0] : 34'h0);
    end
    if (expq.size() != 0) void'(expq.pop_front());
  endtask

  // Watch bus answers and count trigger and pulse cycles between snapshots
  always @(posedge core_clk) begin
    if (bvalid && bready) cmp({bresp, 32'h0});
    if (rvalid && rready) cmp({rresp, rdata});
    if (snap != 2'h0) begin
      if (snap != 2'h3) cmp({2'h0, snap[1] ? 8'h0 : npre, nlate, nhigh});
      npre <= 8'(pretrig_out);
      nlate <= 8'(late_trig_out);
      nhigh <= 16'(pulse_out);
    end else begin
      npre <= npre + 8'(pretrig_out);
      nlate <= nlate + 8'(late_trig_out);
      nhigh <= nhigh + 16'(pulse_out);
    end
  end

  // Register write, response noted first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom);
    forever begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      bready <= 1'b1;
    end
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Register read with expected response and data
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    forever begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Align to the second advance trigger seen
  task automatic sync();
    repeat (2) begin
      @(posedge core_clk);
      while (pretrig_out !== 1'b1) @(posedge core_clk);
    end
  endtask

  // Count over n cycles, then compare with e (s=2 leaves out the advance triggers)
  task automatic win(input int n, input logic [1:0] s, input logic [31:0] e);
    snap <= 2'h3;
    @(posedge core_clk);
    snap <= 2'h0;
    repeat (n - 1) @(posedge core_clk);
    expq.push_back({2'h0, e});
    snap <= s;
    @(posedge core_clk);
    snap <= 2'h0;
    @(posedge core_clk);
  endtask

  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, snap, awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'h9b330dda));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(pms_pkg::CTRL_OFS, {OK, 24'h0, pms_pkg::CTRL_RST});
    rd(pms_pkg::PERIOD_OFS, {OK, pms_pkg::PERIOD_RST});
    rd(pms_pkg::DELAY_OFS, {OK, pms_pkg::DELAY_RST});
    rd(pms_pkg::WIDTH_OFS, {OK, pms_pkg::WIDTH_RST});
    rd(8'h14, {pms_pkg::RESP_SLVERR, 32'h0});
    wr(pms_pkg::STATUS_OFS, 32'h0, pms_pkg::RESP_SLVERR);
    wr(pms_pkg::DELAY_OFS, 32'h4, OK);
    // Only the low byte lane is written, upper lanes keep their old zeros
    wstrb <= 4'h1;
    wr(pms_pkg::WIDTH_OFS, 32'h5a5a5a00 | 32'(W), OK);
    wstrb <= 4'hf;
    rd(pms_pkg::WIDTH_OFS, {OK, 32'(W)});
    // Panel modes, then remote modes with panel on burst and negative polarity
    for (int r = 0; r < 2; r++) begin
      foreach (codes[i]) begin
        p = 12 + int'($urandom % 8);
        hi = (codes[i] == pms_pkg::CODE_DOUBLE) ? 2 * K * W : K * W;
        src.set(1'b1, codes[i]);
        wr(pms_pkg::PERIOD_OFS, 32'(p), OK);
        wr(pms_pkg::CTRL_OFS, r != 0 ? 32'h2b : 32'(codes[i]), OK);
        sync();
        win(K * p, 2'h1, {8'(K), 8'(K), 16'(r != 0 ? K * p - hi : hi)});
      end
    end
    // Gated mode with the gate closed stays silent
    wr(pms_pkg::CTRL_OFS, 32'h4, OK);
    src.set(1'b0, 3'h0);
    repeat (30) @(posedge core_clk);
    rd(pms_pkg::STATUS_OFS, {OK, 32'h10});
    win(60, 2'h1, 32'h0);
    // External source: two triggers and one manual fire
    wr(pms_pkg::CTRL_OFS, 32'h10, OK);
    repeat (30) @(posedge core_clk);
    fork
      win(100, 2'h1, {8'h0, 8'h3, 16'(3 * W)});
      begin
        src.kick();
        repeat (30) @(posedge core_clk);
        src.kick();
        repeat (10) @(posedge core_clk);
        wr(pms_pkg::CTRL_OFS, 32'h50, OK);
        rd(pms_pkg::CTRL_OFS, {OK, 32'h10});
      end
    join
    // A trigger while the clock enable is low leaves no trace
    fork
      win(20, 2'h1, 32'h0);
      begin
        ce <= 1'b0;
        src.kick();
        ce <= 1'b1;
      end
    join
    // Burst: silent until triggered, then three pulses and one late trigger
    wr(pms_pkg::PERIOD_OFS, 32'h10, OK);
    wr(pms_pkg::DELAY_OFS, 32'h28, OK);
    wr(pms_pkg::CTRL_OFS, 32'(pms_pkg::CODE_BURST), OK);
    repeat (40) @(posedge core_clk);
    rd(pms_pkg::STATUS_OFS, {OK, 32'h108});
    win(40, 2'h1, 32'h0);
    // Panel burst, then the same burst selected over the remote inputs
    for (int r = 0; r < 2; r++) begin
      if (r != 0) begin
        src.set(1'b0, pms_pkg::CODE_BURST);
        wr(pms_pkg::CTRL_OFS, 32'h8, OK);
      end
      fork
        win(90, 2'h1, {8'h3, 8'h1, 16'(3 * W)});
        begin
          repeat (5) @(posedge core_clk);
          src.kick();
        end
      join
    end
    report_and_stop();
  end
endmodule // tb_pulse_mode_sequencer
